// ---- hdl/prhg_fifo.sv ----
// parameterised fifo for random words
`timescale 1ns/1ps
module prhg_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 8,
	parameter int AW = 3
) (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic flush,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	typedef struct packed {
		logic [AW:0] wr;
		logic [AW:0] rd;
	} prhg_fifo_st_t;
	prhg_fifo_st_t st;
	prhg_fifo_st_t next_st;
	logic [WIDTH-1:0] mem [DEPTH];
	logic full;
	logic empty;
	assign full = (st.wr[AW] != st.rd[AW]) && (st.wr[AW-1:0] == st.rd[AW-1:0]);
	assign empty = (st.wr == st.rd);
	assign in_ready = !full && !flush;
	assign out_valid = !empty && !flush;
	assign out_data = mem[st.rd[AW-1:0]];
	always_comb begin
		next_st = st;
		if (in_valid && in_ready) begin
			next_st.wr = st.wr + 1'b1;
		end
		if (out_valid && out_ready) begin
			next_st.rd = st.rd + 1'b1;
		end
		if (flush) begin
			next_st = '0;
		end
	end
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end
	always_ff @(posedge sys_clk) begin
		if (in_valid && in_ready) begin
			mem[st.wr[AW-1:0]] <= in_data;
		end
	end
endmodule // prhg_fifo

// ---- hdl/prhg_gate.sv ----
// health gate top: raw bit tests, word packing, gated fifo output
// Contract
// - total failure at start blocks all output
// - failure in operation discards dependent words
// - statistical test at start and continuously
// - no words before start pass or after defect
// - test runs by itself, bounded detection time
// - words delivered as 8 or 16 bits
// - thresholds keep entropy above bound
`timescale 1ns/1ps
module prhg_gate (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic start,
	input wire logic word8,
	input wire logic raw_bit,
	input wire logic raw_strobe,
	output logic [prhg_pkg::WORD_W-1:0] rnd_data,
	output logic rnd_valid,
	input wire logic rnd_ready,
	output logic running,
	output logic ready_ok,
	output logic fail_total,
	output logic fail_stat
);
	import prhg_pkg::*;
	typedef struct packed {
		prhg_state_t state;
		logic wide;
		logic prev;
		logic strobe_d;
		logic [5:0] run;
		logic [7:0] stall;
		logic [WIN_CW-1:0] cnt;
		logic [8:0] ones;
		logic [WORD_W-1:0] shift;
		logic [4:0] nbits;
		logic [WORD_W-1:0] pend;
		logic pend_v;
		logic pass;
		logic ftot;
		logic fstat;
		logic [WORD_W-1:0] odata;
		logic ovalid;
		logic alive;
	} prhg_st_t;
	prhg_st_t st;
	prhg_st_t next_st;
	logic [1:0] sync_q;
	logic bit_s;
	logic strobe_s;
	logic bit_ev;
	logic fifo_in_ready;
	logic fifo_out_valid;
	logic [WORD_W-1:0] fifo_out_data;
	logic fifo_pop;
	logic flush;
	logic win_end;
	logic run_bad;
	logic ones_bad;
	logic [4:0] word_bits;
	// stall limit plus the stall clear stage and the one register stage that sets flag and state
	localparam int DETECT_SPAN = int'(STALL_LIMIT) + 2;
	prhg_sync u_sync (
		.sys_clk(sys_clk),
		.reset_n(reset_n),
		.d({raw_strobe, raw_bit}),
		.q(sync_q)
	);
	assign bit_s = sync_q[0];
	assign strobe_s = sync_q[1];
	assign bit_ev = strobe_s && !st.strobe_d;
	assign word_bits = st.wide ? 5'h10 : 5'h08;
	assign win_end = bit_ev && (st.cnt == WIN_CW'(WIN_BITS - 1));
	assign run_bad = bit_ev && (bit_s == st.prev) && (st.run >= RUN_LIMIT - 6'h01);
	assign ones_bad = win_end && (((st.ones + {8'h00, bit_s}) < ONES_MIN)
		|| ((st.ones + {8'h00, bit_s}) > ONES_MAX));
	assign flush = (st.state != PRHG_RUN) || start;
	assign fifo_pop = fifo_out_valid && (!st.ovalid || rnd_ready) && st.pass;
	prhg_fifo #(
		.WIDTH(WORD_W),
		.DEPTH(FIFO_DEPTH),
		.AW(FIFO_AW)
	) u_fifo (
		.sys_clk(sys_clk),
		.reset_n(reset_n),
		.flush(flush),
		.in_valid(st.pend_v && st.pass),
		.in_ready(fifo_in_ready),
		.in_data(st.pend),
		.out_valid(fifo_out_valid),
		.out_ready(fifo_pop),
		.out_data(fifo_out_data)
	);
	always_comb begin
		next_st = st;
		next_st.strobe_d = strobe_s;
		if (start) begin
			// only a restart or reset_n clears the flags
			next_st = '0;
			next_st.state = PRHG_START;
			next_st.wide = !word8;
			next_st.strobe_d = strobe_s;
			next_st.cnt = WIN_RESET;
		end else begin
			case (st.state)
				PRHG_START, PRHG_RUN: begin
					if (bit_ev) begin
						next_st.stall = 8'h00;
					end else if (st.stall != STALL_LIMIT) begin
						next_st.stall = st.stall + 8'h01;
					end
					if (bit_ev) begin
						// every raw bit enters the test
						next_st.prev = bit_s;
						next_st.run = (bit_s == st.prev) ? st.run + 6'h01 : 6'h01;
						next_st.cnt = win_end ? WIN_RESET : st.cnt + 1'b1;
						next_st.ones = win_end ? 9'h000 : st.ones + {8'h00, bit_s};
						next_st.shift = {st.shift[WORD_W-2:0], bit_s};
						next_st.nbits = st.nbits + 5'h01;
						if (st.nbits + 5'h01 == word_bits) begin
							next_st.nbits = 5'h00;
							// narrow words sit in the low byte
							next_st.pend = st.wide ? {st.shift[WORD_W-2:0], bit_s}
								: {8'h00, st.shift[6:0], bit_s};
							next_st.pend_v = 1'b1;
						end
					end
					if (st.pend_v && st.pass && fifo_in_ready) begin
						next_st.pend_v = 1'b0;
					end
					// start window must pass before run
					if (st.state == PRHG_START && win_end && !ones_bad && !run_bad) begin
						next_st.state = PRHG_RUN;
						next_st.pass = 1'b1;
						next_st.pend_v = 1'b0;
					end
					// failure drops pending and queued words
					if (st.stall == STALL_LIMIT) begin
						next_st.ftot = 1'b1;
						next_st.state = PRHG_FAIL;
					end
					if (run_bad || ones_bad) begin
						next_st.fstat = 1'b1;
						next_st.state = PRHG_FAIL;
					end
					if (next_st.state == PRHG_FAIL) begin
						next_st.pass = 1'b0;
						next_st.pend_v = 1'b0;
					end
				end
				PRHG_FAIL: begin
					next_st.pass = 1'b0;
				end
				default: begin
					next_st.state = PRHG_FAIL;
				end
			endcase
		end
		// output register only fed while passing
		if (fifo_pop) begin
			next_st.odata = fifo_out_data;
			next_st.ovalid = 1'b1;
		end else if (rnd_ready) begin
			next_st.ovalid = 1'b0;
		end
		if (!next_st.pass) begin
			next_st.ovalid = 1'b0;
		end
		// running flag registered with the state
		next_st.alive = (next_st.state != PRHG_FAIL);
	end
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			st <= '0;
			st.state <= PRHG_FAIL;
		end else begin
			st <= next_st;
		end
	end
	assign rnd_data = st.odata;
	assign rnd_valid = st.ovalid;
	assign running = st.alive;
	assign ready_ok = st.pass;
	assign fail_total = st.ftot;
	assign fail_stat = st.fstat;
	sequence s_fail_seen;
		fail_total || fail_stat;
	endsequence
	sequence s_start_pulse;
		start ##1 !start;
	endsequence
	sequence s_enter_fail;
		running ##1 !running;
	endsequence
	sequence s_leave_start;
		st.state == PRHG_START ##1 st.state == PRHG_RUN;
	endsequence
	sequence s_bit_taken;
		bit_ev && running && !start;
	endsequence
	sequence s_word_popped;
		fifo_pop && next_st.pass;
	endsequence
	AST_TOTAL_BLOCK: assert property (@(posedge sys_clk) disable iff (!reset_n)
		fail_total && !start |=> !rnd_valid)
		else $error("word after total failure");
	AST_STALL_FLAG: assert property (@(posedge sys_clk) disable iff (!reset_n)
		(st.stall == STALL_LIMIT) && !start && st.state != PRHG_FAIL |=> fail_total)
		else $error("stalled source not flagged");
	AST_RESTART: assert property (@(posedge sys_clk) disable iff (!reset_n)
		s_start_pulse |-> !ready_ok && running)
		else $error("restart did not reenter start test");
	AST_GATE: assert property (@(posedge sys_clk) disable iff (!reset_n)
		rnd_valid |-> ready_ok && !fail_total && !fail_stat)
		else $error("word presented without pass");
	AST_DETECT: assert property (@(posedge sys_clk) disable iff (!reset_n)
		(run_bad || ones_bad) && running && !start |=> fail_stat && !ready_ok)
		else $error("defect not flagged");
	// narrow words have zero high byte
	AST_NARROW: assert property (@(posedge sys_clk) disable iff (!reset_n)
		rnd_valid && !st.wide |-> rnd_data[15:8] == 8'h00)
		else $error("narrow word has high bits");
	AST_RUNLIM: assert property (@(posedge sys_clk) disable iff (!reset_n)
		ready_ok |-> st.run < RUN_LIMIT)
		else $error("run exceeded limit while passing");
	AST_STICKY: assert property (@(posedge sys_clk) disable iff (!reset_n)
		s_fail_seen ##0 !start |=> s_fail_seen)
		else $error("failure flag cleared without restart");
	AST_HOLD: assert property (@(posedge sys_clk) disable iff (!reset_n)
		rnd_valid && !rnd_ready && !start && next_st.pass |=> rnd_valid
		&& $stable(rnd_data))
		else $error("word dropped under back pressure");
	AST_NO_EARLY: assert property (@(posedge sys_clk) disable iff (!reset_n)
		st.state == PRHG_START |-> !rnd_valid && !fifo_out_valid)
		else $error("word offered during start test");
	AST_FAIL_FLUSH: assert property (@(posedge sys_clk) disable iff (!reset_n)
		s_enter_fail |-> !rnd_valid && !fifo_out_valid && !st.pend_v)
		else $error("words kept after failure");
	AST_FAIL_QUIET: assert property (@(posedge sys_clk) disable iff (!reset_n)
		st.state == PRHG_FAIL |-> !fifo_out_valid && !st.pend_v)
		else $error("word queued while failed");
	AST_FAIL_LOCK: assert property (@(posedge sys_clk) disable iff (!reset_n)
		st.state == PRHG_FAIL && !start |=> st.state == PRHG_FAIL)
		else $error("left failed state without restart");
	AST_RESTART_CLEAR: assert property (@(posedge sys_clk) disable iff (!reset_n)
		s_start_pulse |-> !fail_total && !fail_stat && !rnd_valid)
		else $error("restart left flags or word");
	AST_WIDTH_HOLD: assert property (@(posedge sys_clk) disable iff (!reset_n)
		!start |=> $stable(st.wide))
		else $error("word width changed without restart");
	AST_NARROW_PEND: assert property (@(posedge sys_clk) disable iff (!reset_n)
		st.pend_v && !st.wide |-> st.pend[WORD_W-1:8] == 8'h00)
		else $error("narrow pending word has high bits");
	AST_START_WINDOW: assert property (@(posedge sys_clk) disable iff (!reset_n)
		s_leave_start |-> ready_ok && $past(win_end))
		else $error("run entered before start window ended");
	AST_WIN_COUNT: assert property (@(posedge sys_clk) disable iff (!reset_n)
		win_end && running && !start |=> st.cnt == WIN_RESET && st.ones == 9'h000)
		else $error("test window not restarted");
	AST_DETECT_SPAN: assert property (@(posedge sys_clk) disable iff (!reset_n)
		s_bit_taken |-> ##[1:DETECT_SPAN] (bit_ev || start || !running))
		else $error("stalled source not caught in time");
	AST_TOTAL_START: assert property (@(posedge sys_clk) disable iff (!reset_n)
		s_start_pulse |-> ##[0:DETECT_SPAN] (fail_total || bit_ev || start))
		else $error("silent source not caught after start");
	AST_ALIVE_OUT: assert property (@(posedge sys_clk) disable iff (!reset_n)
		!running |-> !ready_ok && !rnd_valid)
		else $error("output active while stopped");
	AST_FIFO_GATE: assert property (@(posedge sys_clk) disable iff (!reset_n)
		st.pass |-> st.state == PRHG_RUN)
		else $error("pass outside run state");
	AST_POP_LOAD: assert property (@(posedge sys_clk) disable iff (!reset_n)
		s_word_popped |=> rnd_valid && rnd_data == $past(fifo_out_data))
		else $error("popped word not presented");
endmodule // prhg_gate

// ---- hdl/prhg_pkg.sv ----
// constants and types of the rng health gate
package prhg_pkg;
	localparam int WORD_W = 16;
	localparam int FIFO_DEPTH = 8;
	localparam int FIFO_AW = 3;
	// health test window and limits
	localparam int START_BITS = 256;
	localparam int WIN_BITS = 256;
	localparam int WIN_CW = 9;
	localparam logic [8:0] ONES_MIN = 9'h60;
	localparam logic [8:0] ONES_MAX = 9'ha0;
	// repetition count: shortest failing run of one value
	localparam logic [5:0] RUN_LIMIT = 6'h20;
	// stuck source: cycles without a raw bit strobe
	localparam logic [7:0] STALL_LIMIT = 8'h40;
	localparam logic [WIN_CW-1:0] WIN_RESET = 9'h000;
	typedef enum {PRHG_START, PRHG_RUN, PRHG_FAIL} prhg_state_t;
endpackage : prhg_pkg

// ---- hdl/prhg_sync.sv ----
// two flop synchroniser for raw source pins
`timescale 1ns/1ps
module prhg_sync (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic [1:0] d,
	output logic [1:0] q
);
	typedef struct packed {
		logic [1:0] s1;
		logic [1:0] s2;
	} prhg_sync_st_t;
	prhg_sync_st_t st;
	prhg_sync_st_t next_st;
	assign q = st.s2;
	always_comb begin
		next_st.s1 = d;
		next_st.s2 = st.s1;
	end
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end
endmodule // prhg_sync

// ---- test/prhg_consumer.sv ----
// consumer model that takes random words, fast or slow
`timescale 1ns/1ps
module prhg_consumer (
	input wire logic sys_clk,
	input wire logic slow,
	input wire logic rnd_valid,
	input wire logic [prhg_pkg::WORD_W-1:0] rnd_data,
	output logic rnd_ready,
	output logic got,
	output logic [prhg_pkg::WORD_W-1:0] word
);
	import prhg_pkg::*;
	logic [1:0] cnt = 2'h0;
	initial begin
		rnd_ready = 1'b0;
		got = 1'b0;
		word = '0;
	end
	// word is taken at the edge where valid and ready meet
	always @(posedge sys_clk) begin
		got <= rnd_valid && rnd_ready;
		word <= rnd_data;
		cnt <= cnt + 2'h1;
	end
	// slow mode accepts one cycle in four
	always @(posedge sys_clk) begin
		#1 rnd_ready = !slow || cnt == 2'h3;
	end
endmodule // prhg_consumer

// ---- test/tb_top.sv ----
// self-checking bench for the rng health gate
`timescale 1ns/1ps
module tb_top;
	import prhg_pkg::*;
	logic sys_clk = 1'b0;
	logic reset_n = 1'b0;
	logic start = 1'b0;
	logic word8 = 1'b0;
	logic raw_bit = 1'b0;
	logic raw_strobe = 1'b0;
	logic slow = 1'b0;
	logic [WORD_W-1:0] rnd_data;
	logic [WORD_W-1:0] word;
	logic rnd_valid, rnd_ready, running, ready_ok, fail_total, fail_stat, got;
	int errors = 0;
	int check_count = 0;
	int seed = 32'h6439;
	int nbits, wbits, acc, dead;
	int q[$];
	always #50 sys_clk = !sys_clk;
	prhg_gate dut (.sys_clk(sys_clk), .reset_n(reset_n), .start(start), .word8(word8),
		.raw_bit(raw_bit), .raw_strobe(raw_strobe), .rnd_data(rnd_data),
		.rnd_valid(rnd_valid), .rnd_ready(rnd_ready), .running(running),
		.ready_ok(ready_ok), .fail_total(fail_total), .fail_stat(fail_stat));
	prhg_consumer partner (.sys_clk(sys_clk), .slow(slow), .rnd_valid(rnd_valid),
		.rnd_data(rnd_data), .rnd_ready(rnd_ready), .got(got), .word(word));
	task automatic chk_word(string name, logic [WORD_W-1:0] exp, logic [WORD_W-1:0] seen);
		check_count++;
		if (seen !== exp) begin
			errors++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic chk_flag(string name, logic exp, logic seen);
		check_count++;
		if (seen !== exp) begin
			errors++;
			$display("mismatch %s expected %b seen %b", name, exp, seen);
		end
	endtask
	task automatic final_report();
		$display("checks %0d errors %0d", check_count, errors);
		if (errors == 0 && check_count > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	// model first, then one raw bit with a strobe pulse
	task automatic send_bit(logic b);
		nbits++;
		if (dead == 0 && nbits > START_BITS) begin
			acc = acc * 2 + int'(b);
			if ((nbits - START_BITS) % wbits == 0) begin
				q.push_back(acc);
				acc = 0;
			end
		end
		@(posedge sys_clk) #1;
		raw_bit = b;
		raw_strobe = 1'b1;
		repeat (3) @(posedge sys_clk);
		#1 raw_strobe = 1'b0;
		repeat (2) @(posedge sys_clk);
	endtask
	task automatic send_rand(int n);
		repeat (n) send_bit(1'($random(seed)));
	endtask
	task automatic do_start(logic w8);
		@(posedge sys_clk) #1;
		start = 1'b1;
		word8 = w8;
		@(posedge sys_clk) #1;
		start = 1'b0;
		word8 = !w8;
		nbits = 0;
		acc = 0;
		dead = 0;
		wbits = w8 ? 8 : 16;
		q.delete();
		@(posedge sys_clk) #1;
		chk_flag("running", 1'b1, running);
		chk_flag("ready_ok", 1'b0, ready_ok);
		chk_flag("fail_total", 1'b0, fail_total);
		chk_flag("fail_stat", 1'b0, fail_stat);
	endtask
	always @(posedge sys_clk) begin
		if (got === 1'b1) begin
			if (q.size() == 0) begin
				chk_flag("unexpected word", 1'b0, 1'b1);
			end else begin
				chk_word("rnd_data", WORD_W'(q.pop_front()), word);
			end
		end
	end
	initial begin
		repeat (10) @(posedge sys_clk);
		#1 reset_n = 1'b1;
		chk_flag("running", 1'b0, running);
		chk_flag("rnd_valid", 1'b0, rnd_valid);
		do_start(1'b0);
		send_rand(START_BITS);
		repeat (6) @(posedge sys_clk);
		chk_flag("ready_ok", 1'b1, ready_ok);
		slow = 1'b1;
		send_rand(64);
		repeat (40) @(posedge sys_clk);
		chk_word("pending", '0, WORD_W'(q.size()));
		slow = 1'b0;
		do_start(1'b1);
		send_rand(START_BITS + 32);
		repeat (30) @(posedge sys_clk);
		chk_word("pending", '0, WORD_W'(q.size()));
		chk_flag("fail_stat", 1'b0, fail_stat);
		repeat (80) @(posedge sys_clk);
		chk_flag("fail_total", 1'b1, fail_total);
		chk_flag("running", 1'b0, running);
		dead = 1;
		send_rand(8);
		chk_flag("fail_total", 1'b1, fail_total);
		chk_flag("rnd_valid", 1'b0, rnd_valid);
		do_start(1'b0);
		dead = 1;
		repeat (40) send_bit(1'b1);
		chk_flag("fail_stat", 1'b1, fail_stat);
		chk_flag("ready_ok", 1'b0, ready_ok);
		do_start(1'b0);
		dead = 1;
		repeat (80) @(posedge sys_clk);
		chk_flag("fail_total", 1'b1, fail_total);
		chk_flag("rnd_valid", 1'b0, rnd_valid);
		final_report();
	end
	initial begin
		#(100 * 20000);
		errors++;
		final_report();
	end
endmodule // tb_top
